// File: include/rpmc_pkg.sv
package rpmc_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;

  // register byte addresses (printed offsets 0x00 and 0x0F are indices)
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_RSSI = 4'hf;
  localparam logic [7:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [7:0] ADDR_RSSI = {2'b00, IDX_RSSI, 2'b00};
  localparam logic [7:0] ADDR_STAT = 8'h40;

  // control register fields
  localparam int unsigned BIT_STANDBY = 7;
  localparam int unsigned BIT_RF_FULL = 5;
  localparam int unsigned BIT_SWAP    = 3;
  localparam int unsigned BIT_RX_ONLY = 1;
  localparam logic [7:0] CTRL_RESET   = 8'h00;

  // times, in their printed units
  localparam int unsigned WAKE_CONFIRM_US = 100;
  localparam int unsigned STANDBY_REC_US  = 100;
  localparam int unsigned MODE1_REC_US    = 25;
  localparam int unsigned AUX_CLK_HZ      = 60_000;
  localparam int unsigned SETTLE_US_DFLT  = 1500;

  localparam int unsigned WAKE_CONFIRM_CYC = WAKE_CONFIRM_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STANDBY_REC_CYC  = STANDBY_REC_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MODE1_REC_CYC    = MODE1_REC_US * (CLK_HZ / 1_000_000);
  // half period of the auxiliary clock, rounded down
  localparam int unsigned AUX_HALF_CYC     = CLK_HZ / (2 * AUX_CLK_HZ);
  localparam int unsigned SETTLE_CYC_DFLT  = SETTLE_US_DFLT * (CLK_HZ / 1_000_000);

  // power states
  typedef enum logic [2:0] {
    RPMC_OFF    = 3'b000,
    RPMC_SLEEP  = 3'b001,
    RPMC_SETTLE = 3'b011,
    RPMC_WAKE   = 3'b010,
    RPMC_ON     = 3'b110
  } rpmc_state_t;

  // active mode reported in status
  localparam logic [2:0] MODE_PD1     = 3'h0;
  localparam logic [2:0] MODE_PD2     = 3'h1;
  localparam logic [2:0] MODE_STANDBY = 3'h2;
  localparam logic [2:0] MODE_ACT1    = 3'h3;
  localparam logic [2:0] MODE_ACT2    = 3'h4;
  localparam logic [2:0] MODE_ACT34   = 3'h5;

endpackage : rpmc_pkg

// File: core/rpmc_top.sv
//Operation
// - enable high: regulators, oscillator, host clock
// - wake only: auxiliary supply, 60 kHz clock
// - wake rising edge starts supplies, oscillator
// - unconfirmed wake start returns to power-down
// - enable confirmed within window stays active
// - after settling switch to crystal clock
// - enable high: modes from control register
// - standby bit 7, recover in 100 us
// - bits 5,1 clear: mode 1, 25 us
// - bit 1 set: receiver only
// - bit 5 set: whole RF section
// - default input 1 main, 2 auxiliary
// - bit 3 swaps receive inputs
// - both RSSI values stored for reading
// - only main receiver feeds digitizer
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module rpmc_top
  import rpmc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = SETTLE_CYC_DFLT
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hsel,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        enablePin,
  input  wire logic        wakeInput,
  input  wire logic        firstReceiveInput,
  input  wire logic        secondReceiveInput,
  input  wire logic [3:0]  mainRssiLevel,
  input  wire logic [3:0]  auxRssiLevel,
  input  wire logic        rssiValid,
  output logic             regulatorsOn,
  output logic             auxiliaryRegulatedSupply,
  output logic             oscillatorOn,
  output logic             hostClockOutput,
  output logic             hostClockIsCrystal,
  output logic             transmitterOn,
  output logic             receiverOn,
  output logic             mainReceiverIn,
  output logic             auxReceiverIn,
  output logic             digitizerIn,
  output logic             registersReady,
  output logic             recoveryDone
);

  typedef struct packed {
    logic [1:0]  enSync;
    logic [1:0]  wakeSync;
    logic        wakePrev;
    logic [1:0]  rx1Sync;
    logic [1:0]  rx2Sync;
    rpmc_state_t state;
    logic        fromWake;
    logic [31:0] timer;
    logic [31:0] recTimer;
    logic [15:0] auxDiv;
    logic        auxClk;
    logic [7:0]  ctrl;
    logic [7:0]  rssi;
    logic        dpPend;
    logic        dpWrite;
    logic [7:0]  dpAddr;
    logic [31:0] rdata;
    logic        regOn;
    logic        auxSup;
    logic        oscOn;
    logic        hclk;
    logic        hclkXtal;
    logic        txOn;
    logic        rxOn;
    logic        mainIn;
    logic        auxIn;
    logic        digIn;
    logic        ready;
    logic        recDone;
  } rpmc_regs_t;

  rpmc_regs_t s_q;
  rpmc_regs_t s_d;
  // apart from the struct: only this one is cleared by the raw pin
  logic [1:0] rstSync_q;
  logic       rstN;
  logic       en;
  logic       wake;
  logic       wakeRise;
  logic       addrPhase;
  logic [2:0] modeNow;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  assign en       = s_q.enSync[1];
  assign wake     = s_q.wakeSync[1];
  assign wakeRise = wake & ~s_q.wakePrev;
  assign addrPhase = hsel & hready & htrans[1];

  always_comb begin
    modeNow = MODE_PD1;
    case (s_q.state)
      RPMC_SLEEP:  modeNow = MODE_PD2;
      RPMC_ON: begin
        if (s_q.ctrl[BIT_STANDBY]) begin
          modeNow = MODE_STANDBY;
        end else if (s_q.ctrl[BIT_RF_FULL]) begin
          modeNow = MODE_ACT34;
        end else if (s_q.ctrl[BIT_RX_ONLY]) begin
          modeNow = MODE_ACT2;
        end else begin
          modeNow = MODE_ACT1;
        end
      end
      default:     modeNow = MODE_PD1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d          = s_q;
    s_d.enSync   = {s_q.enSync[0], enablePin};
    s_d.wakeSync = {s_q.wakeSync[0], wakeInput};
    s_d.rx1Sync  = {s_q.rx1Sync[0], firstReceiveInput};
    s_d.rx2Sync  = {s_q.rx2Sync[0], secondReceiveInput};
    s_d.wakePrev = wake;

    // 60 kHz divider, free-running; host clock gated by the auxiliary supply
    if (s_q.auxDiv >= 16'(AUX_HALF_CYC - 1)) begin
      s_d.auxDiv = 16'h0000;
      s_d.auxClk = ~s_q.auxClk;
    end else begin
      s_d.auxDiv = s_q.auxDiv + 16'h0001;
    end

    if (s_q.timer != 32'h0000_0000) begin
      s_d.timer = s_q.timer - 32'h0000_0001;
    end

    case (s_q.state)
      RPMC_OFF: begin
        if (en) begin
          s_d.state    = RPMC_SETTLE;
          s_d.fromWake = 1'b0;
          s_d.timer    = SETTLE_CYC;
        end else if (wakeRise) begin
          s_d.state    = RPMC_SETTLE;
          s_d.fromWake = 1'b1;
          s_d.timer    = SETTLE_CYC;
        end else if (wake) begin
          s_d.state = RPMC_SLEEP;
        end
      end
      RPMC_SLEEP: begin
        if (en) begin
          s_d.state    = RPMC_SETTLE;
          s_d.fromWake = 1'b0;
          s_d.timer    = SETTLE_CYC;
        end else if (!wake) begin
          s_d.state = RPMC_OFF;
        end
      end
      RPMC_SETTLE: begin
        if (s_q.timer == 32'h0000_0000) begin
          if (s_q.fromWake && !en) begin
            s_d.state = RPMC_WAKE;
            s_d.timer = WAKE_CONFIRM_CYC;
          end else begin
            s_d.state = RPMC_ON;
          end
        end else if (!s_q.fromWake && !en) begin
          s_d.state = wake ? RPMC_SLEEP : RPMC_OFF;
        end
      end
      RPMC_WAKE: begin
        if (en) begin
          s_d.state = RPMC_ON;
        end else if (s_q.timer == 32'h0000_0000) begin
          s_d.state = RPMC_OFF;
        end
      end
      RPMC_ON: begin
        if (!en) begin
          s_d.state = wake ? RPMC_SLEEP : RPMC_OFF;
        end
      end
      default: s_d.state = RPMC_OFF;
    endcase

    if (s_q.recTimer != 32'h0000_0000) begin
      s_d.recTimer = s_q.recTimer - 32'h0000_0001;
    end

    // AHB-Lite slave, zero wait states
    s_d.dpPend = addrPhase;
    if (addrPhase) begin
      s_d.dpWrite = hwrite;
      s_d.dpAddr  = haddr[7:0];
    end
    if (s_q.dpPend && s_q.dpWrite && s_q.dpAddr == ADDR_CTRL) begin
      s_d.ctrl = hwdata[7:0];
      if (s_q.ctrl[BIT_STANDBY] && !hwdata[BIT_STANDBY]) begin
        s_d.recTimer = STANDBY_REC_CYC;
      end else if (!s_q.ctrl[BIT_RF_FULL] && !s_q.ctrl[BIT_RX_ONLY]
                   && (hwdata[BIT_RF_FULL] || hwdata[BIT_RX_ONLY])) begin
        s_d.recTimer = MODE1_REC_CYC;
      end
    end
    if (rssiValid) begin
      s_d.rssi = {auxRssiLevel, mainRssiLevel};
    end
    if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        ADDR_CTRL: s_d.rdata = {24'h000000, s_d.ctrl};
        ADDR_RSSI: s_d.rdata = {24'h000000, s_q.rssi};
        ADDR_STAT: s_d.rdata = {24'h000000, s_q.recTimer == 32'h0000_0000,
                                s_q.state == RPMC_ON, s_q.fromWake,
                                s_q.state == RPMC_WAKE, 1'b0, modeNow};
        default:   s_d.rdata = 32'h0000_0000;
      endcase
    end

    // outputs
    // supplies and oscillator
    s_d.regOn    = (s_d.state != RPMC_OFF) && (s_d.state != RPMC_SLEEP);
    s_d.oscOn    = s_d.regOn && !(s_d.state == RPMC_ON && s_d.ctrl[BIT_STANDBY]);
    s_d.auxSup   = s_d.state != RPMC_OFF;
    s_d.hclkXtal = (s_d.state == RPMC_ON) || (s_d.state == RPMC_WAKE);
    s_d.hclk     = s_d.hclkXtal ? 1'b0 : (s_d.auxSup & s_d.auxClk);
    s_d.ready    = s_d.hclkXtal;
    // full RF, receiver only, mode 1 off
    s_d.txOn     = s_d.state == RPMC_ON && !s_d.ctrl[BIT_STANDBY] && s_d.ctrl[BIT_RF_FULL];
    s_d.rxOn     = s_d.state == RPMC_ON && !s_d.ctrl[BIT_STANDBY]
                   && (s_d.ctrl[BIT_RF_FULL] || s_d.ctrl[BIT_RX_ONLY]);
    s_d.mainIn   = s_d.ctrl[BIT_SWAP] ? s_q.rx2Sync[1] : s_q.rx1Sync[1];
    s_d.auxIn    = s_d.ctrl[BIT_SWAP] ? s_q.rx1Sync[1] : s_q.rx2Sync[1];
    s_d.digIn    = s_d.rxOn & s_d.mainIn;
    s_d.recDone  = s_d.recTimer == 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s_q.enSync   <= 2'b00;
      s_q.wakeSync <= 2'b00;
      s_q.wakePrev <= 1'b0;
      s_q.rx1Sync  <= 2'b00;
      s_q.rx2Sync  <= 2'b00;
      s_q.state    <= RPMC_OFF;
      s_q.fromWake <= 1'b0;
      s_q.timer    <= 32'h0000_0000;
      s_q.recTimer <= 32'h0000_0000;
      s_q.auxDiv   <= 16'h0000;
      s_q.auxClk   <= 1'b0;
      s_q.ctrl     <= CTRL_RESET;
      s_q.rssi     <= 8'h00;
      s_q.dpPend   <= 1'b0;
      s_q.dpWrite  <= 1'b0;
      s_q.dpAddr   <= 8'h00;
      s_q.rdata    <= 32'h0000_0000;
      s_q.regOn    <= 1'b0;
      s_q.auxSup   <= 1'b0;
      s_q.oscOn    <= 1'b0;
      s_q.hclk     <= 1'b0;
      s_q.hclkXtal <= 1'b0;
      s_q.txOn     <= 1'b0;
      s_q.rxOn     <= 1'b0;
      s_q.mainIn   <= 1'b0;
      s_q.auxIn    <= 1'b0;
      s_q.digIn    <= 1'b0;
      s_q.ready    <= 1'b0;
      s_q.recDone  <= 1'b1;
    end else begin
      s_q.enSync   <= s_d.enSync;
      s_q.wakeSync <= s_d.wakeSync;
      s_q.wakePrev <= s_d.wakePrev;
      s_q.rx1Sync  <= s_d.rx1Sync;
      s_q.rx2Sync  <= s_d.rx2Sync;
      s_q.state    <= s_d.state;
      s_q.fromWake <= s_d.fromWake;
      s_q.timer    <= s_d.timer;
      s_q.recTimer <= s_d.recTimer;
      s_q.auxDiv   <= s_d.auxDiv;
      s_q.auxClk   <= s_d.auxClk;
      s_q.ctrl     <= s_d.ctrl;
      s_q.rssi     <= s_d.rssi;
      s_q.dpPend   <= s_d.dpPend;
      s_q.dpWrite  <= s_d.dpWrite;
      s_q.dpAddr   <= s_d.dpAddr;
      s_q.rdata    <= s_d.rdata;
      s_q.regOn    <= s_d.regOn;
      s_q.auxSup   <= s_d.auxSup;
      s_q.oscOn    <= s_d.oscOn;
      s_q.hclk     <= s_d.hclk;
      s_q.hclkXtal <= s_d.hclkXtal;
      s_q.txOn     <= s_d.txOn;
      s_q.rxOn     <= s_d.rxOn;
      s_q.mainIn   <= s_d.mainIn;
      s_q.auxIn    <= s_d.auxIn;
      s_q.digIn    <= s_d.digIn;
      s_q.ready    <= s_d.ready;
      s_q.recDone  <= s_d.recDone;
    end
  end

  // zero wait states; response always okay
  assign hreadyout                = 1'b1;
  assign hresp                    = 1'b0;
  assign hrdata                   = s_q.rdata;
  assign regulatorsOn             = s_q.regOn;
  assign auxiliaryRegulatedSupply = s_q.auxSup;
  assign oscillatorOn             = s_q.oscOn;
  assign hostClockOutput          = s_q.hclk;
  assign hostClockIsCrystal       = s_q.hclkXtal;
  assign transmitterOn            = s_q.txOn;
  assign receiverOn               = s_q.rxOn;
  assign mainReceiverIn           = s_q.mainIn;
  assign auxReceiverIn            = s_q.auxIn;
  assign digitizerIn              = s_q.digIn;
  assign registersReady           = s_q.ready;
  assign recoveryDone             = s_q.recDone;

endmodule : rpmc_top

// File: bench/rpmc_top_asserts.sv
`timescale 1ns/1ps
module rpmc_top_asserts
  import rpmc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = SETTLE_CYC_DFLT
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic enablePin,
  input wire logic wakeInput,
  input wire logic regulatorsOn,
  input wire logic auxiliaryRegulatedSupply,
  input wire logic oscillatorOn,
  input wire logic hostClockOutput,
  input wire logic hostClockIsCrystal,
  input wire logic transmitterOn,
  input wire logic receiverOn,
  input wire logic mainReceiverIn,
  input wire logic digitizerIn,
  input wire logic registersReady
);
  logic [31:0] loneCnt_q;
  logic [31:0] auxCnt_q;
  logic [31:0] settleCnt_q;
  logic        hckPrev_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      loneCnt_q   <= '0;
      auxCnt_q    <= '0;
      settleCnt_q <= '0;
      hckPrev_q   <= 1'b0;
    end else begin
      loneCnt_q   <= (hostClockIsCrystal && !enablePin) ? loneCnt_q + 32'h1 : '0;
      auxCnt_q    <= (auxiliaryRegulatedSupply && !hostClockIsCrystal &&
                      hostClockOutput == hckPrev_q) ? auxCnt_q + 32'h1 : '0;
      settleCnt_q <= (regulatorsOn && !hostClockIsCrystal) ? settleCnt_q + 32'h1 : '0;
      hckPrev_q   <= hostClockOutput;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  sequence s_wakeRise;
    $rose(wakeInput) && !enablePin && !auxiliaryRegulatedSupply;
  endsequence
  sequence s_enHeld;
    enablePin [*8];
  endsequence
  property p_supply_order;
    regulatorsOn |-> auxiliaryRegulatedSupply;
  endproperty
  property p_enable_on;
    s_enHeld |=> regulatorsOn;
  endproperty
  property p_wake_start;
    s_wakeRise |-> ##[2:8] regulatorsOn;
  endproperty
  property p_wake_expire;
    loneCnt_q <= WAKE_CONFIRM_CYC + 8;
  endproperty
  property p_settle_first;
    $rose(hostClockIsCrystal) |-> settleCnt_q >= SETTLE_CYC - 1;
  endproperty
  property p_xtal_ready;
    hostClockIsCrystal |-> registersReady && !hostClockOutput;
  endproperty
  property p_aux_clock;
    auxCnt_q <= AUX_HALF_CYC + 2;
  endproperty
  property p_standby_quiet;
    regulatorsOn && !oscillatorOn |-> !transmitterOn && !receiverOn;
  endproperty
  property p_tx_needs_rx;
    transmitterOn |-> receiverOn;
  endproperty
  property p_digitizer_main;
    (!mainReceiverIn) [*2] |-> !digitizerIn;
  endproperty
  a_supply_order: assert property (p_supply_order)
    else $error("regulators on without aux supply");
  a_enable_on: assert property (p_enable_on)
    else $error("enable held but regulators off");
  a_wake_start: assert property (p_wake_start)
    else $error("wake edge did not start supplies");
  a_wake_expire: assert property (p_wake_expire)
    else $error("wake window overran");
  a_settle_first: assert property (p_settle_first)
    else $error("crystal clock before settling");
  a_xtal_ready: assert property (p_xtal_ready)
    else $error("crystal clock without ready");
  a_aux_clock: assert property (p_aux_clock)
    else $error("aux clock stalled");
  a_standby_quiet: assert property (p_standby_quiet)
    else $error("rf active in standby");
  a_tx_needs_rx: assert property (p_tx_needs_rx)
    else $error("transmitter without receiver");
  a_digitizer_main: assert property (p_digitizer_main)
    else $error("digitizer fed without main input");
endmodule : rpmc_top_asserts

bind rpmc_top rpmc_top_asserts #(.SETTLE_CYC(SETTLE_CYC)) i_rpmc_top_asserts (
  .clock, .arst_n, .enablePin, .wakeInput, .regulatorsOn, .auxiliaryRegulatedSupply,
  .oscillatorOn, .hostClockOutput, .hostClockIsCrystal, .transmitterOn, .receiverOn,
  .mainReceiverIn, .digitizerIn, .registersReady);

// File: bench/rpmc_host_model.sv
`timescale 1ns/1ps
module rpmc_host_model #(
  parameter int unsigned GAP_CYC = 500000
) (
  input  wire logic clock,
  input  wire logic wantEnable,
  input  wire logic wantWake,
  output logic      enablePin,
  output logic      wakeInput
);
  int unsigned sinceEn = GAP_CYC;
  int unsigned sinceWake = GAP_CYC;
  initial begin
    enablePin = 1'b0;
    wakeInput = 1'b0;
  end
  // spacing between pins, one pin per cycle, enable never rises over wake
  always @(posedge clock) begin
    sinceEn <= sinceEn + 1;
    sinceWake <= sinceWake + 1;
    if (wantEnable !== enablePin && sinceWake >= GAP_CYC && !(wantEnable && wakeInput)) begin
      enablePin <= wantEnable;
      sinceEn <= 0;
    end else if (wantWake !== wakeInput && sinceEn >= GAP_CYC) begin
      wakeInput <= wantWake;
      sinceWake <= 0;
    end
  end
endmodule : rpmc_host_model

// File: bench/reader_power_mode_control_bench.sv
`timescale 1ns/1ps
module reader_power_mode_control_bench;
  import rpmc_pkg::*;
  localparam int unsigned SETTLE = 20;
  localparam int unsigned GAP    = 50;
  logic        clock, arst_n, hwrite, rx1, rx2, rssiValid, wantEn, wantWake, h;
  logic        enablePin, wakeInput, hreadyout, hresp, regOn, auxOn, oscOn, hck, xtal;
  logic        txOn, rxOn, mainIn, auxIn, digIn, ready, recDone;
  logic [1:0]  htrans;
  logic [3:0]  mainRssi, auxRssi;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  mv [4] = '{8'h00, 8'h02, 8'h20, 8'ha0};
  logic [2:0]  ev [4] = '{3'b001, 3'b011, 3'b111, 3'b000};
  logic [2:0]  em [4] = '{MODE_ACT1, MODE_ACT2, MODE_ACT34, MODE_STANDBY};
  int          fail_count, n_compared, k;
  wire  [4:0]  obs = {hck, recDone, xtal, auxOn, regOn};

  rpmc_top #(.SETTLE_CYC(SETTLE)) i_rpmc_top (
    .clock(clock), .arst_n(arst_n), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .enablePin(enablePin), .wakeInput(wakeInput),
    .firstReceiveInput(rx1), .secondReceiveInput(rx2), .mainRssiLevel(mainRssi),
    .auxRssiLevel(auxRssi), .rssiValid(rssiValid), .regulatorsOn(regOn),
    .auxiliaryRegulatedSupply(auxOn), .oscillatorOn(oscOn), .hostClockOutput(hck),
    .hostClockIsCrystal(xtal), .transmitterOn(txOn), .receiverOn(rxOn),
    .mainReceiverIn(mainIn), .auxReceiverIn(auxIn), .digitizerIn(digIn),
    .registersReady(ready), .recoveryDone(recDone));
  rpmc_host_model #(.GAP_CYC(GAP)) i_rpmc_host_model (
    .clock(clock), .wantEnable(wantEn), .wantWake(wantWake),
    .enablePin(enablePin), .wakeInput(wakeInput));

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic waitb(input int b, input logic v, input int lim);
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (obs[b] !== v && k < lim);
    if (obs[b] !== v) begin
      check("wait", 32'(b), 32'hff);
      end_sim();
    end
  endtask : waitb
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic pins(input logic en, input logic wk);
    @(posedge clock);
    wantEn   <= en;
    wantWake <= wk;
  endtask : pins
  task automatic recov(input logic [7:0] m, input int n);
    bus(1'b1, ADDR_CTRL, {24'h0, m});
    repeat (4) @(negedge clock);
    bus(1'b1, ADDR_CTRL, 32'h20);
    waitb(3, 1'b0, 8);
    waitb(3, 1'b1, n + 50);
    check("recovery", 32'(k + 8 >= n && k <= n + 8), 32'h1);
  endtask : recov

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    check("timeout", 32'h0, 32'h1);
    end_sim();
  end
  initial begin
    {arst_n, hwrite, rx1, rx2, rssiValid, wantEn, wantWake} = '0;
    {htrans, mainRssi, auxRssi, haddr, hwdata} = '0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl reset", rd, {24'h0, CTRL_RESET});
    bus(1'b1, ADDR_CTRL, 32'hffff_ff5a);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl rw", rd, 32'h5a);
    @(posedge clock);
    {mainRssi, auxRssi, rssiValid} <= {4'h5, 4'ha, 1'b1};
    @(posedge clock);
    {mainRssi, rssiValid} <= {4'h3, 1'b0};
    bus(1'b1, ADDR_RSSI, 32'h0);
    bus(1'b0, ADDR_RSSI, 32'h0);
    check("rssi", rd, 32'ha5);
    bus(1'b0, 8'h80, 32'h0);
    check("unmapped", rd, 32'h0);
    check("okay", 32'(hresp), 32'h0);
    pins(1'b1, 1'b0);
    waitb(0, 1'b1, 200);
    waitb(2, 1'b1, SETTLE + 200);
    check("ready", 32'(ready), 32'h1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_CTRL, {24'h0, mv[i]});
      repeat (4) @(negedge clock);
      check("mode", 32'({txOn, rxOn, oscOn}), 32'(ev[i]));
      bus(1'b0, ADDR_STAT, 32'h0);
      check("status", 32'(rd[6:0]), 32'({4'h8, em[i]}));
    end
    recov(8'h80, STANDBY_REC_CYC);
    recov(8'h00, MODE1_REC_CYC);
    @(posedge clock);
    {rx1, rx2} <= 2'b10;
    bus(1'b1, ADDR_CTRL, 32'h20);
    repeat (6) @(negedge clock);
    check("route", 32'({mainIn, auxIn, digIn}), 32'h5);
    bus(1'b1, ADDR_CTRL, 32'h28);
    repeat (6) @(negedge clock);
    check("swap", 32'({mainIn, auxIn, digIn}), 32'h2);
    pins(1'b0, 1'b0);
    waitb(0, 1'b0, 200);
    check("aux off", 32'(auxOn), 32'h0);
    for (int j = 0; j < 2; j++) begin
      pins(1'b0, 1'b1);
      waitb(0, 1'b1, GAP + 100);
      pins(1'b0, 1'b0);
      waitb(2, 1'b1, SETTLE + 100);
      if (j == 0) begin
        waitb(0, 1'b0, WAKE_CONFIRM_CYC + 50);
        check("window", 32'(k + 50 >= WAKE_CONFIRM_CYC), 32'h1);
      end else begin
        pins(1'b1, 1'b0);
        repeat (WAKE_CONFIRM_CYC + 100) @(negedge clock);
        check("confirmed", 32'(regOn), 32'h1);
      end
    end
    pins(1'b1, 1'b1);
    repeat (GAP + 10) @(negedge clock);
    pins(1'b0, 1'b1);
    waitb(0, 1'b0, GAP + 200);
    check("sleep supply", 32'(auxOn), 32'h1);
    h = hck;
    waitb(4, ~h, AUX_HALF_CYC + 20);
    waitb(4, h, AUX_HALF_CYC + 20);
    check("aux clock", 32'(k + 2 >= AUX_HALF_CYC && k <= AUX_HALF_CYC + 2), 32'h1);
    end_sim();
  end
endmodule : reader_power_mode_control_bench
